// ### verilog/dpg_config_bank.v
/*
 Configuration bank at 0x1c..0x26: watchdog key, processor start
 masks, interrupt routing, two pulse outputs, pin direction and
 pull-up, bandgap control, power_on_conversion_launch and gain correction.
 Assumes a byte write/read port driven by the serial interface and
 that the host keeps the run switch off while configuring.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dpg_defs.vh"
module dpg_config_bank #(
   parameter WD_PERIOD = `DPG_WD_CYCLES,
   parameter BG_PULSE = 8
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register port from the serial interface
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_r,
   // Run switch and event sources
   input wire front_end_run_switch,
   input wire capacitance_conversion_done,
   input wire resistance_conversion_done,
   input wire timer_tick,
   input wire result_read_done,
   input wire processor_bandgap_request,
   input wire watchdog_kick,
   input wire interrupt_request_low,
   input wire [3:0] processor_input,
   // General pins
   input wire [3:0] general_pin_in,
   input wire [1:0] pin45_normal_out,
   // Oscillator ticks and pulse duty codes
   input wire lf_tick,
   input wire fast_tick,
   input wire [15:0] pulse0_duty,
   input wire [15:0] pulse1_duty,
   // Outputs
   output reg processor_start_r,
   output reg [3:0] processor_input_capture_r,
   output reg [1:0] pin45_out_r,
   output reg [3:0] general_pin_oe_r,
   output reg [3:0] general_pin_pullup_r,
   output reg bandgap_power_r,
   output reg bandgap_refresh_r,
   output reg conversion_launch_r,
   output reg watchdog_reset_r,
   output reg [8:0] gain_factor_r,
   output reg [7:0] bandgap_settle_r,
   output reg pulse0_out_r,
   output reg pulse1_out_r
);
   reg [7:0] wdkey_r, pinmask_r, irqtrig_r, pulse0_r, pulse1_r;
   reg [7:0] pindir_r, bgctl_r, gain_r, bgtime_r;
   reg [7:0] unused_a_r, unused_b_r;
   reg [7:0] wdkey_nxt, pinmask_nxt, irqtrig_nxt, pulse0_nxt, pulse1_nxt;
   reg [7:0] pindir_nxt, bgctl_nxt, gain_nxt, bgtime_nxt;
   reg [7:0] unused_a_nxt, unused_b_nxt;
   reg [7:0] rdata_nxt;
   reg [3:0] bg_cnt_r;
   reg por_done_r;
   wire wd_exp;
   wire p0, p1;
   wire [7:0] bg_len;
   wire bg_req;
   wire pin_start;
   wire [10:0] sel;
   wire [10:0] wsel;
   // One-hot register select, shared by the write and read paths so
   // both always agree on which addresses are mapped
   function [10:0] reg_sel;
      input [7:0] a;
      begin
         case (a)
            `DPG_ADDR_WDKEY: reg_sel = 11'h001;
            `DPG_ADDR_PINMASK: reg_sel = 11'h002;
            `DPG_ADDR_IRQTRIG: reg_sel = 11'h004;
            `DPG_ADDR_PULSE0: reg_sel = 11'h008;
            `DPG_ADDR_PULSE1: reg_sel = 11'h010;
            `DPG_ADDR_PINDIR: reg_sel = 11'h020;
            `DPG_ADDR_BGCTL: reg_sel = 11'h040;
            `DPG_ADDR_GAIN: reg_sel = 11'h080;
            `DPG_ADDR_UNUSED_A: reg_sel = 11'h100;
            `DPG_ADDR_UNUSED_B: reg_sel = 11'h200;
            `DPG_ADDR_BGTIME: reg_sel = 11'h400;
            default: reg_sel = 11'h000;
         endcase
      end
   endfunction
   // Writes land only while the run switch is off, so a running
   // front end never sees a half-changed setting
   wire wr_ok = reg_wr && !front_end_run_switch;
   assign sel = reg_sel(reg_addr);
   assign wsel = wr_ok ? sel : 11'h000;
   always @* begin
      wdkey_nxt = wdkey_r;
      pinmask_nxt = pinmask_r;
      irqtrig_nxt = irqtrig_r;
      pulse0_nxt = pulse0_r;
      pulse1_nxt = pulse1_r;
      pindir_nxt = pindir_r;
      bgctl_nxt = bgctl_r;
      gain_nxt = gain_r;
      unused_a_nxt = unused_a_r;
      unused_b_nxt = unused_b_r;
      bgtime_nxt = bgtime_r;
      if (wsel[0])
         wdkey_nxt = reg_wdata;
      if (wsel[1])
         pinmask_nxt = reg_wdata;
      // Unused bits of 0x1e and 0x20 read back as zero
      if (wsel[2])
         irqtrig_nxt = reg_wdata & 8'hc7;
      if (wsel[3])
         pulse0_nxt = reg_wdata;
      if (wsel[4])
         pulse1_nxt = reg_wdata & 8'h3f;
      if (wsel[5])
         pindir_nxt = reg_wdata;
      if (wsel[6])
         bgctl_nxt = reg_wdata;
      if (wsel[7])
         gain_nxt = reg_wdata;
      if (wsel[8])
         unused_a_nxt = reg_wdata;
      if (wsel[9])
         unused_b_nxt = reg_wdata;
      if (wsel[10])
         bgtime_nxt = reg_wdata;
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wdkey_r <= `DPG_RST_WDKEY;
         pinmask_r <= `DPG_RST_PINMASK;
         irqtrig_r <= `DPG_RST_IRQTRIG;
         pulse0_r <= `DPG_RST_PULSE;
         pulse1_r <= `DPG_RST_PULSE;
         pindir_r <= `DPG_RST_PINDIR;
         bgctl_r <= `DPG_RST_BGCTL;
         gain_r <= `DPG_RST_GAIN;
         bgtime_r <= `DPG_RST_BGTIME;
         unused_a_r <= 8'h00;
         unused_b_r <= 8'h00;
      end else begin
         wdkey_r <= wdkey_nxt;
         pinmask_r <= pinmask_nxt;
         irqtrig_r <= irqtrig_nxt;
         pulse0_r <= pulse0_nxt;
         pulse1_r <= pulse1_nxt;
         pindir_r <= pindir_nxt;
         bgctl_r <= bgctl_nxt;
         gain_r <= gain_nxt;
         bgtime_r <= bgtime_nxt;
         unused_a_r <= unused_a_nxt;
         unused_b_r <= unused_b_nxt;
      end
   end
   // Unmapped addresses read as zero
   always @* begin
      rdata_nxt = 8'h00;
      if (sel[0])
         rdata_nxt = wdkey_r;
      if (sel[1])
         rdata_nxt = pinmask_r;
      if (sel[2])
         rdata_nxt = irqtrig_r;
      if (sel[3])
         rdata_nxt = pulse0_r;
      if (sel[4])
         rdata_nxt = pulse1_r;
      if (sel[5])
         rdata_nxt = pindir_r;
      if (sel[6])
         rdata_nxt = bgctl_r;
      if (sel[7])
         rdata_nxt = gain_r;
      if (sel[8])
         rdata_nxt = unused_a_r;
      if (sel[9])
         rdata_nxt = unused_b_r;
      if (sel[10])
         rdata_nxt = bgtime_r;
   end
   dpg_watchdog #(.PERIOD(WD_PERIOD)) u_wd (
      .clk(clk),
      .rst(rst),
      .enable(wdkey_r != `DPG_WD_OFF_KEY),
      .kick(watchdog_kick),
      .expired_r(wd_exp)
   );
   dpg_pulse_gen u_p0 (
      .clk(clk),
      .rst(rst),
      .resolution(pulse0_r[5:4]),
      .modulation_type(pulse0_r[`DPG_BIT_PDM]),
      .clock_source(pulse0_r[2:0]),
      .toggle_stage(pulse0_r[`DPG_BIT_TGL0]),
      .duty(pulse0_duty),
      .lf_tick(lf_tick),
      .fast_tick(fast_tick),
      .pulse_out_r(p0)
   );
   dpg_pulse_gen u_p1 (
      .clk(clk),
      .rst(rst),
      .resolution(pulse1_r[5:4]),
      .modulation_type(pulse1_r[`DPG_BIT_PDM]),
      .clock_source(pulse1_r[2:0]),
      .toggle_stage(pulse0_r[`DPG_BIT_TGL1]),
      .duty(pulse1_duty),
      .lf_tick(lf_tick),
      .fast_tick(fast_tick),
      .pulse_out_r(p1)
   );
   assign pin_start = |(pinmask_r[7:4] & general_pin_in & pindir_r[7:4]);
   assign bg_req = (bgctl_r[`DPG_BIT_BG_READ] && result_read_done) ||
                   (bgctl_r[`DPG_BIT_BG_PROC] && processor_bandgap_request);
   // Low nibble other than the mandatory 7 shortens the bandgap hold to one cycle
   assign bg_len = (bgctl_r[3:0] == `DPG_BG_MANDATORY) ? BG_PULSE[7:0] :
                   8'h01;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata_r <= 8'h00;
         processor_start_r <= 1'b0;
         processor_input_capture_r <= 4'h0;
         pin45_out_r <= 2'h0;
         general_pin_oe_r <= 4'h0;
         general_pin_pullup_r <= 4'h0;
         bandgap_power_r <= 1'b0;
         bandgap_refresh_r <= 1'b0;
         bg_cnt_r <= 4'h0;
         conversion_launch_r <= 1'b0;
         por_done_r <= 1'b0;
         watchdog_reset_r <= 1'b0;
         gain_factor_r <= 9'h000;
         bandgap_settle_r <= 8'h00;
         pulse0_out_r <= 1'b0;
         pulse1_out_r <= 1'b0;
      end else begin
         if (reg_rd)
            reg_rdata_r <= rdata_nxt;
         // Enabled trigger sources start the processor
         processor_start_r <= pin_start ||
            (irqtrig_r[0] && capacitance_conversion_done) ||
            (irqtrig_r[1] && resistance_conversion_done) ||
            (irqtrig_r[2] && timer_tick);
         processor_input_capture_r <= processor_input & pinmask_r[3:0];
         // Interrupt routing overrides normal pin function
         pin45_out_r[1] <= irqtrig_r[`DPG_BIT_IRQ5] ?
                           interrupt_request_low : pin45_normal_out[1];
         pin45_out_r[0] <= irqtrig_r[`DPG_BIT_IRQ4] ?
                           interrupt_request_low : pin45_normal_out[0];
         // Clear direction bit drives the pin
         general_pin_oe_r <= ~pindir_r[7:4];
         general_pin_pullup_r <= pindir_r[3:0];
         bandgap_refresh_r <= bg_req;
         if (bg_req)
            bg_cnt_r <= bg_len[3:0];
         else if (bg_cnt_r != 4'h0)
            bg_cnt_r <= bg_cnt_r - 4'h1;
         bandgap_power_r <= bgctl_r[`DPG_BIT_BANDGAP_ALWAYS_ON] || bg_req ||
                            (bg_cnt_r != 4'h0);
         // One launch per reset, the first time power_on_conversion_launch is
         // seen set, so a loaded setting launches as a reset value would
         por_done_r <= por_done_r || bgctl_r[`DPG_BIT_POWER_ON_CONVERSION_LAUNCH];
         conversion_launch_r <= !por_done_r &&
                                bgctl_r[`DPG_BIT_POWER_ON_CONVERSION_LAUNCH];
         watchdog_reset_r <= wd_exp;
         // Factor scaled by 256: zero code means no correction
         gain_factor_r <= (gain_r == 8'h00) ? 9'h100 : {1'b1, gain_r};
         bandgap_settle_r <= bgtime_r;
         pulse0_out_r <= p0;
         pulse1_out_r <= p1;
      end
   end
endmodule
`default_nettype wire

// ### verilog/dpg_defs.vh
/*
 Constants for the pulse, pin and bandgap configuration bank:
 register addresses, field positions, reset values and timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DPG_DEFS_VH
`define DPG_DEFS_VH
`define DPG_ADDR_WDKEY 8'h1c
`define DPG_ADDR_PINMASK 8'h1d
`define DPG_ADDR_IRQTRIG 8'h1e
`define DPG_ADDR_PULSE0 8'h1f
`define DPG_ADDR_PULSE1 8'h20
`define DPG_ADDR_PINDIR 8'h21
`define DPG_ADDR_BGCTL 8'h22
`define DPG_ADDR_GAIN 8'h23
`define DPG_ADDR_UNUSED_A 8'h24
`define DPG_ADDR_UNUSED_B 8'h25
`define DPG_ADDR_BGTIME 8'h26
`define DPG_WD_OFF_KEY 8'h5a
`define DPG_RST_WDKEY 8'h00
`define DPG_RST_PINMASK 8'h00
`define DPG_RST_IRQTRIG 8'h02
`define DPG_RST_PULSE 8'h00
`define DPG_RST_PINDIR 8'hf0
`define DPG_RST_BGCTL 8'h07
`define DPG_RST_GAIN 8'h40
`define DPG_RST_BGTIME 8'h00
`define DPG_BG_MANDATORY 4'h7
`define DPG_BIT_IRQ5 7
`define DPG_BIT_IRQ4 6
`define DPG_BIT_TGL1 7
`define DPG_BIT_TGL0 6
`define DPG_BIT_PDM 3
`define DPG_BIT_BG_READ 7
`define DPG_BIT_BG_PROC 6
`define DPG_BIT_BANDGAP_ALWAYS_ON 5
`define DPG_BIT_POWER_ON_CONVERSION_LAUNCH 4
`define DPG_CLK_MHZ 50
`define DPG_WD_MIN_S 9
`define DPG_WD_MAX_S 15
`define DPG_WD_CYCLES (`DPG_WD_MIN_S * `DPG_CLK_MHZ * 1000000)
`endif

// ### verilog/dpg_pulse_gen.v
/*
 One pulse-code output: PWM or PDM of a duty code at a selectable
 resolution, paced by a chosen oscillator tick and divider, with an
 optional toggle stage. Assumes the tick inputs are one-cycle pulses
 in the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module dpg_pulse_gen (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Configuration
   input wire [1:0] resolution,
   input wire modulation_type,
   input wire [2:0] clock_source,
   input wire toggle_stage,
   input wire [15:0] duty,
   // Oscillator ticks
   input wire lf_tick,
   input wire fast_tick,
   // Output
   output reg pulse_out_r
);
   reg [1:0] div_r;
   reg [15:0] cnt_r;
   reg [16:0] acc_r;
   reg raw_r;
   reg tgl_r;
   wire src_tick;
   wire step;
   wire [15:0] top;
   wire [15:0] d;
   wire [16:0] sum;
   // Codes 1-3 low oscillator, 4-6 fast; 0 and undefined 7 stop
   assign src_tick = (clock_source >= 3'h1 && clock_source <= 3'h3) ?
                     lf_tick :
                     (clock_source >= 3'h4 && clock_source <= 3'h6) ?
                     fast_tick : 1'b0;
   assign step = src_tick && (clock_source == 3'h1 ||
                 clock_source == 3'h4 ||
                 ((clock_source == 3'h2 || clock_source == 3'h5) &&
                  div_r[0]) || div_r == 2'h3);
   // Resolution 10, 12, 14 or 16 bits
   assign top = 16'hffff >> {resolution ^ 2'h3, 1'b0};
   assign d = duty & top;
   assign sum = {1'b0, acc_r[15:0] & top} + {1'b0, d};
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         div_r <= 2'h0;
         cnt_r <= 16'h0000;
         acc_r <= 17'h00000;
         raw_r <= 1'b0;
         tgl_r <= 1'b0;
         pulse_out_r <= 1'b0;
      end else begin
         if (src_tick)
            div_r <= div_r + 2'h1;
         if (step) begin
            cnt_r <= (cnt_r >= top) ? 16'h0000 : cnt_r + 16'h0001;
            acc_r <= sum;
            if (modulation_type)
               raw_r <= sum[{1'b0, resolution, 1'b0} + 5'd10];
            else
               raw_r <= (cnt_r < d);
            if (modulation_type ? sum[{1'b0, resolution, 1'b0} + 5'd10]
                : (cnt_r < d))
               tgl_r <= ~tgl_r;
         end
         if (clock_source == 3'h0 || clock_source == 3'h7)
            pulse_out_r <= 1'b0;
         else
            pulse_out_r <= toggle_stage ? tgl_r : raw_r;
      end
   end
endmodule
`default_nettype wire

// ### verilog/dpg_watchdog.v
/*
 Watchdog timer: counts while enabled, raises a one-cycle expiry and
 restarts. Assumes kick is a one-cycle pulse from the processor side.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dpg_defs.vh"
module dpg_watchdog #(
   parameter PERIOD = `DPG_WD_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Control
   input wire enable,
   input wire kick,
   // Status
   output reg expired_r
);
   reg [31:0] cnt_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 32'h0;
         expired_r <= 1'b0;
      end else begin
         expired_r <= 1'b0;
         if (!enable || kick)
            cnt_r <= 32'h0;
         else if (cnt_r >= PERIOD - 1) begin
            cnt_r <= 32'h0;
            expired_r <= 1'b1;
         end else
            cnt_r <= cnt_r + 32'h1;
      end
   end
endmodule
`default_nettype wire

// ### dv/dpg_config_bank_assertions.sv
/*
 Checker for the configuration bank ports.
 Assumes binding into dpg_config_bank with a short watchdog period.
*/
`timescale 1ns/10ps
`default_nettype none
module dpg_config_bank_assertions (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register port
   input wire reg_wr,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire front_end_run_switch,
   // Events
   input wire capacitance_conversion_done,
   input wire resistance_conversion_done,
   input wire timer_tick,
   input wire result_read_done,
   input wire processor_bandgap_request,
   input wire [3:0] general_pin_in,
   // Outputs
   input wire processor_start_r,
   input wire [3:0] general_pin_oe_r,
   input wire [3:0] general_pin_pullup_r,
   input wire bandgap_power_r,
   input wire bandgap_refresh_r,
   input wire watchdog_reset_r,
   input wire [8:0] gain_factor_r
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wire wr_ok = reg_wr && !front_end_run_switch;
   reg [7:0] key_r;
   // Shadow of the key, since the checker cannot see the register
   always @(posedge clk or posedge rst) begin
      if (rst)
         key_r <= 8'h00;
      else if (wr_ok && reg_addr == 8'h1c)
         key_r <= reg_wdata;
   end
   chk_gain_write: assert property (wr_ok && reg_addr == 8'h23 |->
      ##2 gain_factor_r == 9'h100 + $past(reg_wdata, 2))
      else $error("gain factor wrong");
   chk_pin_dir: assert property (wr_ok && reg_addr == 8'h21 |->
      ##2 general_pin_oe_r == ~$past(reg_wdata[7:4], 2)
      && general_pin_pullup_r == $past(reg_wdata[3:0], 2))
      else $error("pin direction or pull-up wrong");
   chk_run_refuse: assert property (front_end_run_switch [*3] |->
      $stable(gain_factor_r) && $stable(general_pin_oe_r))
      else $error("write taken while running");
   chk_refresh_cause: assert property (bandgap_refresh_r |->
      $past(result_read_done) || $past(processor_bandgap_request))
      else $error("refresh without request");
   chk_refresh_power: assert property (bandgap_refresh_r |->
      bandgap_power_r)
      else $error("refresh without power");
   chk_start_cause: assert property (processor_start_r |->
      $past(capacitance_conversion_done) ||
      $past(resistance_conversion_done) || $past(timer_tick) ||
      ($past(general_pin_in) != 4'h0))
      else $error("start without source");
   chk_wd_spacing: assert property (watchdog_reset_r |=>
      !watchdog_reset_r [*8])
      else $error("watchdog expired too soon");
   chk_wd_key: assert property ((key_r == 8'h5a) [*3] |->
      !watchdog_reset_r)
      else $error("watchdog ran while disabled");
endmodule
`default_nettype wire

// ### dv/dpg_host_model.sv
/*
 Host model driving the register port and the run switch.
 Assumes the bench calls its tasks; lines change at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module dpg_host_model (
   // Clock
   input wire clk,
   // Register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic front_end_run_switch
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      front_end_run_switch = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = (a == 8'h22) ? {d[7:4], 4'h7} : d;
      @(negedge clk);
      reg_wr = 1'b0;
      // Released lines show the inverse, not a stale value
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      repeat (2) @(negedge clk);
   endtask
   task automatic run(input logic on);
      @(negedge clk);
      front_end_run_switch = on;
   endtask
endmodule
`default_nettype wire

// ### dv/test_dpg_config_bank.sv
/*
 Bench for the configuration bank: reads, writes, events, watchdog.
 Assumes a 20-cycle watchdog period set at the instance.
*/
`timescale 1ns/10ps
`default_nettype none
module test_dpg_config_bank;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] src = 3'h0;
   logic [1:0] bg = 2'h0;
   logic irq_n = 1'b1, lf = 1'b0, fx = 1'b0;
   logic [3:0] pin_in = 4'h0, p_in = 4'h0;
   logic [1:0] norm = 2'h3;
   logic [15:0] d0 = 16'h0, d1 = 16'h0;
   wire wr, rd, run, st, bp, br, cl, wd, o0, o1;
   wire [7:0] addr, wdata, rdata, settle;
   wire [3:0] cap, oe, pu;
   wire [1:0] p45;
   wire [8:0] gain;
   int n_fail = 0, comparisons = 0, cyc = 0, n_st = 0, n_br = 0, n_wd = 0;
   int n_cl = 0, n_o0 = 0, n_o1 = 0;
   logic fx_all = 1'b0, o1_q = 1'b0;
   int i, j, k;
   logic [7:0] a, d, e, mem [0:10];
   logic [7:0] rv [0:10] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'hf0,
      8'h07, 8'h40, 8'h00, 8'h00, 8'h00};
   logic [7:0] exp_q [$];
   logic rd_q = 1'b0, rd_q2 = 1'b0;
   always #10 clk = ~clk;
   dpg_host_model host (.clk(clk), .reg_wr(wr), .reg_rd(rd),
      .reg_addr(addr), .reg_wdata(wdata), .front_end_run_switch(run));
   dpg_config_bank #(.WD_PERIOD(20)) dut (.clk(clk), .rst(rst),
      .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata_r(rdata), .front_end_run_switch(run),
      .capacitance_conversion_done(src[0]),
      .resistance_conversion_done(src[1]), .timer_tick(src[2]),
      .result_read_done(bg[0]), .processor_bandgap_request(bg[1]),
      .watchdog_kick(1'b0), .interrupt_request_low(irq_n),
      .processor_input(p_in), .general_pin_in(pin_in),
      .pin45_normal_out(norm), .lf_tick(lf), .fast_tick(fx),
      .pulse0_duty(d0), .pulse1_duty(d1), .processor_start_r(st),
      .processor_input_capture_r(cap), .pin45_out_r(p45),
      .general_pin_oe_r(oe), .general_pin_pullup_r(pu),
      .bandgap_power_r(bp), .bandgap_refresh_r(br),
      .conversion_launch_r(cl), .watchdog_reset_r(wd),
      .gain_factor_r(gain), .bandgap_settle_r(settle),
      .pulse0_out_r(o0), .pulse1_out_r(o1));
   function automatic logic [7:0] fit(input logic [7:0] a, d);
      case (a)
         8'h1e: fit = d & 8'hc7;
         8'h20: fit = d & 8'h3f;
         8'h22: fit = {d[7:4], 4'h7};
         default: fit = d;
      endcase
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t output %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask
   task automatic pulse(input logic [2:0] s, input logic [1:0] b);
      @(negedge clk);
      src = s;
      bg = b;
      @(negedge clk);
      src = 3'h0;
      bg = 2'h0;
      repeat (3) @(negedge clk);
   endtask
   task automatic final_report;
      $display("comparisons %0d failures %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      rd_q <= rd;
      rd_q2 <= rd_q;
      n_st += st;
      n_br += br;
      n_wd += wd;
      n_cl += cl;
      n_o0 += o0;
      n_o1 += (o1 && !o1_q);
      o1_q <= o1;
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report;
      end
   end
   always @(negedge clk) begin
      {lf, fx} <= fx_all ? 2'h1 : 2'($urandom);
      if (rd_q2 === 1'b1) begin
         e = exp_q.pop_front();
         cmp_rd(rdata, e);
      end
   end
   initial begin
      void'($urandom(32'h3b87));
      d0 = 16'($urandom);
      d1 = 16'($urandom);
      p_in = 4'($urandom);
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      for (i = 0; i < 11; i++) rd_exp(8'h1c + 8'(i), rv[i]);
      rd_exp(8'h1b, 8'h00);
      rd_exp(8'h27, 8'h00);
      check(16'(gain), 16'h140);
      check(16'(o0), 16'h0);
      $display("test reset done");
      for (i = 0; i < 11; i++) begin
         a = 8'h1c + 8'(i);
         mem[i] = 8'($urandom);
         host.wr(a, mem[i]);
         if (i != 8 && i != 9) rd_exp(a, fit(a, mem[i]));
      end
      check(16'(gain), 16'h100 + 16'(mem[7]));
      check(16'(oe), 16'(4'(~mem[5][7:4])));
      check(16'(pu), 16'(mem[5][3:0]));
      check(16'(settle), 16'(mem[10]));
      check(16'(cap), 16'(p_in & mem[1][3:0]));
      host.run(1'b1);
      host.wr(8'h23, ~mem[7]);
      rd_exp(8'h23, mem[7]);
      host.run(1'b0);
      $display("test write done");
      host.wr(8'h1d, 8'h00);
      for (i = 0; i < 3; i++) begin
         host.wr(8'h1e, 8'h01 << i);
         k = n_st;
         for (j = 0; j < 3; j++) pulse(3'h1 << j, 2'h0);
         check(16'(n_st - k), 16'h1);
      end
      host.wr(8'h21, 8'hf0);
      for (i = 0; i < 2; i++) begin
         host.wr(8'h1d, i ? 8'h20 : 8'h10);
         k = n_st;
         pin_in = 4'h1;
         repeat (3) @(negedge clk);
         pin_in = 4'h0;
         repeat (3) @(negedge clk);
         check(16'(n_st > k), i ? 16'h0 : 16'h1);
      end
      $display("test start done");
      host.wr(8'h22, 8'hc0);
      k = n_br;
      pulse(3'h0, 2'h1);
      pulse(3'h0, 2'h2);
      check(16'(n_br - k), 16'h2);
      host.wr(8'h22, 8'h00);
      k = n_br;
      pulse(3'h0, 2'h3);
      check(16'(n_br - k), 16'h0);
      host.wr(8'h22, 8'h30);
      repeat (2) @(negedge clk);
      check(16'(bp), 16'h1);
      check(16'(n_cl), 16'h1);
      irq_n = 1'b0;
      host.wr(8'h1e, 8'hc0);
      @(negedge clk);
      check(16'(p45), 16'h0);
      host.wr(8'h1e, 8'h40);
      @(negedge clk);
      check(16'(p45), 16'h2);
      // Fast tick every cycle: a 10-bit period is 1024 cycles, so two
      // periods hold twice the duty in highs and one toggle per pulse
      fx_all = 1'b1;
      host.wr(8'h1f, 8'h84);
      host.wr(8'h20, 8'h0c);
      repeat (8) @(negedge clk);
      k = n_o0;
      j = n_o1;
      repeat (2048) @(negedge clk);
      check(16'(n_o0 - k), {5'h0, d0[9:0], 1'b0});
      check(16'(n_o1 - j), {6'h0, d1[9:0]});
      fx_all = 1'b0;
      host.wr(8'h1f, 8'h07);
      host.wr(8'h20, 8'h07);
      repeat (20) @(negedge clk);
      check(16'({o1, o0}), 16'h0);
      $display("test events done");
      host.wr(8'h1c, 8'h00);
      k = n_wd;
      repeat (50) @(negedge clk);
      check(16'(n_wd - k >= 2), 16'h1);
      host.wr(8'h1c, 8'h5a);
      repeat (3) @(negedge clk);
      k = n_wd;
      repeat (50) @(negedge clk);
      check(16'(n_wd - k), 16'h0);
      $display("test watchdog done");
      final_report;
   end
endmodule
bind dpg_config_bank dpg_config_bank_assertions chk (.clk(clk), .rst(rst),
   .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .front_end_run_switch(front_end_run_switch),
   .capacitance_conversion_done(capacitance_conversion_done),
   .resistance_conversion_done(resistance_conversion_done),
   .timer_tick(timer_tick), .result_read_done(result_read_done),
   .processor_bandgap_request(processor_bandgap_request),
   .general_pin_in(general_pin_in), .processor_start_r(processor_start_r),
   .general_pin_oe_r(general_pin_oe_r),
   .general_pin_pullup_r(general_pin_pullup_r),
   .bandgap_power_r(bandgap_power_r), .bandgap_refresh_r(bandgap_refresh_r),
   .watchdog_reset_r(watchdog_reset_r), .gain_factor_r(gain_factor_r));
`default_nettype wire
